//--- rtl/eisp_port_select_high.sv
// upper external-interrupt source select, lines 13..11, avalon-mm slave
`timescale 1ns/1ps
`default_nettype none
`include "eisp_map.svh"
module eisp_port_select_high
  import eisp_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rst,
  // avalon-mm slave
  input  wire logic [`EISP_ADDR_W-1:0] address,
  input  wire logic                    read,
  input  wire logic                    write,
  input  wire logic [31:0]             writedata,
  input  wire logic [3:0]              byteenable,
  output logic      [31:0]             readdata,
  output logic      [1:0]              response,
  output logic                         waitrequest,
  // pin 11..13 of each bank, index 0 is bank a
  input  wire logic [`EISP_NBANK-1:0]  bank_pin13,
  input  wire logic [`EISP_NBANK-1:0]  bank_pin12,
  input  wire logic [`EISP_NBANK-1:0]  bank_pin11,
  // selected sources toward the edge and flag logic
  output logic                         ext_irq_line13,
  output logic                         ext_irq_line12,
  output logic                         ext_irq_line11
);
  eisp_bus_state_t state_q;
  eisp_bus_state_t state_d;
  logic [31:0]     readdata_d;
  logic [1:0]      response_d;
  logic            waitrequest_d;
  eisp_sel_t       line13_source_sel;
  eisp_sel_t       line12_source_sel;
  eisp_sel_t       line11_source_sel;
  logic            bad13;
  logic            bad12;
  logic            bad11;

  // decode
  wire req      = read | write;
  wire hit_selh = (address == `EISP_SELH_OFS);
  wire hit_stat = (address == `EISP_STAT_OFS);
  wire mapped   = hit_selh | hit_stat;
  // write lands on the edge where waitrequest is seen low
  wire accept   = (state_q == EISP_ANSWER);
  wire wr_selh  = accept & write & hit_selh;
  // fields 13 and 12 live in byte 2, field 11 in byte 1
  wire wr_l13   = wr_selh & byteenable[2];
  wire wr_l12   = wr_selh & byteenable[2];
  wire wr_l11   = wr_selh & byteenable[1];

  // read images; unused bits 19, 15 and the rest read zero
  // unused bits zero
  wire [31:0] selh_image = (32'(line13_source_sel) << `EISP_L13_LSB)
                         | (32'(line12_source_sel) << `EISP_L12_LSB)
                         | (32'(line11_source_sel) << `EISP_L11_LSB);
  wire [31:0] stat_image = (32'({ext_irq_line13, ext_irq_line12, ext_irq_line11})
                            << `EISP_STAT_LVL_LSB)
                         | (32'({bad13, bad12, bad11}) << `EISP_STAT_BAD_LSB);
  wire [31:0] rd_mux     = hit_selh ? selh_image :
                           hit_stat ? stat_image : 32'h0000_0000;

  // select fields; bits 19 and 15 are not stored
  // reserved bits dropped
  eisp_sel_field #(
    .RST_VAL (`EISP_SEL_RST)
  ) u_field13 (
    .clk     (clk),
    .rst     (rst),
    .wr_en   (wr_l13),
    .wdata   (writedata[`EISP_L13_LSB +: `EISP_SEL_W]),
    .field_q (line13_source_sel)
  );

  eisp_sel_field #(
    .RST_VAL (`EISP_SEL_RST)
  ) u_field12 (
    .clk     (clk),
    .rst     (rst),
    .wr_en   (wr_l12),
    .wdata   (writedata[`EISP_L12_LSB +: `EISP_SEL_W]),
    .field_q (line12_source_sel)
  );

  eisp_sel_field #(
    .RST_VAL (`EISP_SEL_RST)
  ) u_field11 (
    .clk     (clk),
    .rst     (rst),
    .wr_en   (wr_l11),
    .wdata   (writedata[`EISP_L11_LSB +: `EISP_SEL_W]),
    .field_q (line11_source_sel)
  );

  eisp_src_mux #(
    .NBANK (`EISP_NBANK)
  ) u_mux13 (
    .clk       (clk),
    .rst       (rst),
    .sel       (line13_source_sel),
    .bank_pins (bank_pin13),
    .line_q    (ext_irq_line13),
    .sel_bad   (bad13)
  );

  eisp_src_mux #(
    .NBANK (`EISP_NBANK)
  ) u_mux12 (
    .clk       (clk),
    .rst       (rst),
    .sel       (line12_source_sel),
    .bank_pins (bank_pin12),
    .line_q    (ext_irq_line12),
    .sel_bad   (bad12)
  );

  eisp_src_mux #(
    .NBANK (`EISP_NBANK)
  ) u_mux11 (
    .clk       (clk),
    .rst       (rst),
    .sel       (line11_source_sel),
    .bank_pins (bank_pin11),
    .line_q    (ext_irq_line11),
    .sel_bad   (bad11)
  );

  // bus handshake: one wait cycle, then one answer cycle
  always_comb begin
    state_d       = state_q;
    readdata_d    = readdata;
    response_d    = response;
    waitrequest_d = 1'b1;
    case (state_q)
      EISP_IDLE: begin
        if (req) begin
          state_d       = EISP_ANSWER;
          waitrequest_d = 1'b0;
          readdata_d    = read ? rd_mux : 32'h0000_0000;
          response_d    = mapped ? `EISP_RESP_OK : `EISP_RESP_SLVERR;
        end
      end
      EISP_ANSWER: begin
        state_d = EISP_IDLE;
      end
      default: begin
        state_d = EISP_IDLE;
      end
    endcase
  end

  // bus registers; waitrequest idles high
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q     <= EISP_IDLE;
      readdata    <= 32'h0000_0000;
      response    <= `EISP_RESP_OK;
      waitrequest <= 1'b1;
    end else begin
      state_q     <= state_d;
      readdata    <= readdata_d;
      response    <= response_d;
      waitrequest <= waitrequest_d;
    end
  end
endmodule : eisp_port_select_high
`default_nettype wire

//--- rtl/eisp_map.svh
// offsets, field positions, reset values and codes of the port-select block
`ifndef EISP_MAP_SVH
`define EISP_MAP_SVH

// byte addresses on the register bus
`define EISP_ADDR_W        12
`define EISP_SELH_OFS      12'h104
`define EISP_STAT_OFS      12'h108

// select field layout
`define EISP_SEL_W         3
`define EISP_SEL_RST       3'h0
`define EISP_L13_LSB       20
`define EISP_L12_LSB       16
`define EISP_L11_LSB       12

// status register layout
`define EISP_STAT_LVL_LSB  0
`define EISP_STAT_BAD_LSB  4

// bank choice codes
`define EISP_BANK_A        3'h0
`define EISP_BANK_B        3'h1
`define EISP_BANK_C        3'h2
`define EISP_BANK_D        3'h3
`define EISP_BANK_E        3'h4
`define EISP_BANK_F        3'h5
`define EISP_NBANK         6

// avalon response codes
`define EISP_RESP_OK       2'h0
`define EISP_RESP_SLVERR   2'h2

`endif

//--- rtl/eisp_pkg.sv
// types shared by the port-select block
package eisp_pkg;
  typedef logic [2:0] eisp_sel_t;
  typedef enum logic [2:0] {
    bank_a_choice,
    bank_b_choice,
    bank_c_choice,
    bank_d_choice,
    bank_e_choice,
    bank_f_choice
  } eisp_bank_t;
  typedef enum {EISP_IDLE, EISP_ANSWER} eisp_bus_state_t;
endpackage : eisp_pkg

//--- rtl/eisp_sel_field.sv
// one read-write select field with reset to bank a
`timescale 1ns/1ps
`default_nettype none
`include "eisp_map.svh"
module eisp_sel_field
  import eisp_pkg::*;
#(
  parameter eisp_sel_t RST_VAL = `EISP_SEL_RST
) (
  input  wire logic      clk,
  input  wire logic      rst,
  input  wire logic      wr_en,
  input  wire eisp_sel_t wdata,
  output var  eisp_sel_t field_q
);
  // field store, cleared by reset
  always_ff @(posedge clk) begin
    if (rst) begin
      field_q <= RST_VAL;
    end else if (wr_en) begin
      field_q <= wdata;
    end
  end
endmodule : eisp_sel_field
`default_nettype wire

//--- rtl/eisp_src_mux.sv
// one line: picks the pin of the selected bank, registered
`timescale 1ns/1ps
`default_nettype none
`include "eisp_map.svh"
module eisp_src_mux
  import eisp_pkg::*;
#(
  parameter int NBANK = `EISP_NBANK
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire eisp_sel_t        sel,
  input  wire logic [NBANK-1:0] bank_pins,
  output logic                  line_q,
  output logic                  sel_bad
);
  logic pick;

  // codes past the last bank connect nothing
  // codes 6,7 idle
  assign sel_bad = (32'(sel) >= NBANK);
  assign pick    = sel_bad ? 1'b0 : bank_pins[sel];

  // registered line output
  always_ff @(posedge clk) begin
    if (rst) begin
      line_q <= 1'b0;
    end else begin
      line_q <= pick;
    end
  end
endmodule : eisp_src_mux
`default_nettype wire

//--- dv/eisp_psh_monitor.sv
// assertions on the ports of the upper port-select block
`timescale 1ns/1ps
`default_nettype none
`include "eisp_map.svh"
module eisp_psh_monitor
  import eisp_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [11:0] address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] readdata,
  input wire logic [1:0]  response,
  input wire logic        waitrequest,
  input wire logic [5:0]  bank_pin13,
  input wire logic [5:0]  bank_pin12,
  input wire logic [5:0]  bank_pin11,
  input wire logic        ext_irq_line13,
  input wire logic        ext_irq_line12,
  input wire logic        ext_irq_line11
);
  eisp_sel_t s13_q, s12_q, s11_q;
  wire logic hit = !waitrequest && address == `EISP_SELH_OFS;
  // shadow of the fields, loaded on the answer edge
  always_ff @(posedge clk) begin
    if (rst) begin
      {s13_q, s12_q, s11_q} <= 9'h0;
    end else if (write && hit) begin
      if (byteenable[2]) {s13_q, s12_q} <= {writedata[22:20], writedata[18:16]};
      if (byteenable[1]) s11_q <= writedata[14:12];
    end
  end
  function automatic logic pick(eisp_sel_t s, logic [5:0] p);
    return s < 3'h6 ? p[s] : 1'b0;
  endfunction : pick
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_l13; !$past(rst) |->
    ext_irq_line13 == pick($past(s13_q), $past(bank_pin13)); endproperty
  a_l13: assert property (p_l13) else $error("line 13 source wrong");
  property p_l12; !$past(rst) |->
    ext_irq_line12 == pick($past(s12_q), $past(bank_pin12)); endproperty
  a_l12: assert property (p_l12) else $error("line 12 source wrong");
  property p_l11lo; !$past(rst) && $past(s11_q) < 3'h3 |->
    ext_irq_line11 == $past(bank_pin11[s11_q]); endproperty
  a_l11lo: assert property (p_l11lo) else $error("line 11 low bank wrong");
  property p_l11hi; !$past(rst) && $past(s11_q) inside {[3'h3:3'h5]} |->
    ext_irq_line11 == $past(bank_pin11[s11_q]); endproperty
  a_l11hi: assert property (p_l11hi) else $error("line 11 high bank wrong");
  property p_bad13; !$past(rst) && $past(s13_q) > 3'h5 |-> !ext_irq_line13; endproperty
  a_bad13: assert property (p_bad13) else $error("line 13 not idle");
  property p_bad11; !$past(rst) && $past(s11_q) > 3'h5 |-> !ext_irq_line11; endproperty
  a_bad11: assert property (p_bad11) else $error("line 11 not idle");
  property p_rdbk; read && hit |->
    readdata == {9'h0, s13_q, 1'b0, s12_q, 1'b0, s11_q, 12'h0}; endproperty
  a_rdbk: assert property (p_rdbk) else $error("select readback wrong");
  property p_ok; read && hit |-> response == `EISP_RESP_OK; endproperty
  a_ok: assert property (p_ok) else $error("select read response");
endmodule : eisp_psh_monitor
bind eisp_port_select_high eisp_psh_monitor eisp_psh_monitor_i (.*);
`default_nettype wire

//--- dv/eisp_port_select_high_tb_top.sv
// self-checking bench for the upper port-select block
`timescale 1ns/1ps
`default_nettype none
`include "eisp_map.svh"
module eisp_port_select_high_tb_top
  import eisp_pkg::*;
;
  logic        clk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0;
  logic [11:0] address = 12'h0;
  logic [31:0] writedata = 32'h0, readdata, rd;
  logic [3:0]  byteenable = 4'h0;
  logic [5:0]  bank_pin13 = 6'h0, bank_pin12 = 6'h0, bank_pin11 = 6'h0;
  logic [1:0]  response, rsp;
  logic        waitrequest, ext_irq_line13, ext_irq_line12, ext_irq_line11;
  logic [2:0]  c;
  int          err_total = 0, checked = 0, cyc = 0;
  eisp_port_select_high eisp_port_select_high_i (.clk, .rst, .address, .read, .write,
    .writedata, .byteenable, .readdata, .response, .waitrequest, .bank_pin13,
    .bank_pin12, .bank_pin11, .ext_irq_line13, .ext_irq_line12, .ext_irq_line11);
  always #50 clk = ~clk;
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      end_of_test();
    end
  end
  function automatic logic [31:0] word(logic [2:0] a, logic [2:0] b, logic [2:0] d);
    return {9'h0, a, 1'b0, b, 1'b0, d, 12'h0};
  endfunction : word
  function automatic logic [31:0] pick(logic [2:0] s, logic [5:0] p);
    return s < 3'h6 ? 32'(p[s]) : 32'h0;
  endfunction : pick
  // status word: line levels in 2:0, bad-code flags in 6:4
  function automatic logic [31:0] stat(logic [2:0] a, logic [2:0] b, logic [2:0] d);
    return (32'({a > 3'h5, b > 3'h5, d > 3'h5}) << `EISP_STAT_BAD_LSB)
         | (pick(a, bank_pin13) << (`EISP_STAT_LVL_LSB + 2))
         | (pick(b, bank_pin12) << (`EISP_STAT_LVL_LSB + 1))
         | (pick(d, bank_pin11) << `EISP_STAT_LVL_LSB);
  endfunction : stat
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(logic w, logic [11:0] a, logic [31:0] d, logic [3:0] be);
    @(posedge clk);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= d;
    byteenable <= be;
    do @(posedge clk); while (waitrequest !== 1'b0);
    rd = readdata;
    rsp = response;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  initial begin
    void'($urandom(32'h6603));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, `EISP_SELH_OFS, 32'h0, 4'hf);
    chk("reset word", 32'h0, rd);
    $display("test reset done");
    // every code in every field, reserved bits zero
    for (int k = 0; k < 8; k++) begin
      c = 3'(k);
      bus(1'b1, `EISP_SELH_OFS, word(c, c + 3'h1, c + 3'h2), 4'hf);
      bus(1'b0, `EISP_SELH_OFS, 32'h0, 4'hf);
      chk("select word", word(c, c + 3'h1, c + 3'h2), rd);
      bank_pin13 <= 6'($urandom);
      bank_pin12 <= 6'($urandom);
      bank_pin11 <= 6'($urandom);
      repeat (3) @(posedge clk);
      chk("line 13", pick(c, bank_pin13), 32'(ext_irq_line13));
      chk("line 12", pick(c + 3'h1, bank_pin12), 32'(ext_irq_line12));
      chk("line 11", pick(c + 3'h2, bank_pin11), 32'(ext_irq_line11));
      bus(1'b0, `EISP_STAT_OFS, 32'h0, 4'hf);
      chk("status", stat(c, c + 3'h1, c + 3'h2), rd);
    end
    $display("test codes done");
    bus(1'b1, `EISP_SELH_OFS, word(3'h1, 3'h1, 3'h5), 4'h2);
    bus(1'b0, `EISP_SELH_OFS, 32'h0, 4'hf);
    chk("lane write", word(3'h7, 3'h0, 3'h5), rd);
    bus(1'b0, 12'h200, 32'h0, 4'hf);
    chk("unmapped data", 32'h0, rd);
    chk("unmapped resp", 32'(`EISP_RESP_SLVERR), 32'(rsp));
    $display("test lanes done");
    // second reset in mid-run: fields back to bank a
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, `EISP_SELH_OFS, 32'h0, 4'hf);
    chk("reset again word", 32'h0, rd);
    chk("line 11 after reset", pick(3'h0, bank_pin11), 32'(ext_irq_line11));
    $display("test reset again done");
    end_of_test();
  end
endmodule : eisp_port_select_high_tb_top
`default_nettype wire
